/* File: src/crp_core.v */
// Call/return, port, bus and expander I/O execution unit with timer flags.
// Assumes software issues one instruction at a time through APB.
// Function
// [RULE1] Call is two bytes, two cycles; pushes PC and upper status bits first
// [RULE2] Call then bumps stack pointer, loads PC low 11 bits and bank flag
// [RULE3] Plain return 83h pops PC only, status untouched, interrupts stay off
// [RULE4] Restoring return 93h pops PC and status, enables interrupts at end
// [RULE5] Port input 08h plus port loads accumulator from port 1 or 2
// [RULE6] Port output 38h plus port latches accumulator onto port 1 or 2
// [RULE7] Port AND 98h and OR 88h plus port combine port with data byte
// [RULE8] Bus input 08h reads bus port into accumulator in two cycles
// [RULE9] Bus output 02h latches accumulator onto bus port in two cycles
// [RULE10] Bus AND 98h and OR 88h combine bus port with second byte
// [RULE11] Expander input puts port nibble in accumulator low, clears high
// [RULE12] Expander output 3Ch plus select sends accumulator low nibble out
// [RULE13] Expander AND 9Ch and OR 8Ch combine port with accumulator nibble
// [RULE14] Low two opcode bits select expander port 4 to 7
// [RULE15] Reset clears timer flags and enables, sets global interrupt enable
// [RULE16] Timer overflow sets timer flag, and request when timer enable set
// [RULE17] Timer enable op sets timer interrupt enable, disable op clears it
// [RULE18] External enable op sets external enable, disable op clears it
// [RULE19] Stack pointer is three bits and wraps modulo eight
//
// Decided for this implementation: the APB interface to the registers and the address map.
`include "crp_map.vh"
module crp_core (
    // Clock and reset
    input wire CLK,
    input wire SYS_RST,
    // APB slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // Ports 1 and 2
    input wire [7:0] P1_IN,
    output wire [7:0] P1_OUT,
    input wire [7:0] P2_IN,
    output wire [7:0] P2_OUT,
    // Bus port
    input wire [7:0] BUS_IN,
    output wire [7:0] BUS_OUT,
    output wire BUS_OE,
    // Expander strobe, active low
    output wire EXP_STB_N,
    // Timer overflow event
    input wire TMR_OVF,
    // Flags
    output wire TMR_IRQ,
    output wire GIE
);
    localparam ST_IDLE = 3'b001;
    localparam ST_EX1 = 3'b010;
    localparam ST_EX2 = 3'b100;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [7:0] op_q;
    reg [7:0] arg_q;
    reg [7:0] acc_q;
    reg [11:0] pc_q;
    reg [3:0] stw_q;
    reg bank_q;
    reg [2:0] sp_q;
    reg [7:0] p1_q;
    reg [7:0] p2_q;
    reg [7:0] bus_q;
    reg bus_oe_q;
    reg tflg_q;
    reg tirq_q;
    reg tie_q;
    reg eie_q;
    reg gie_q;
    reg ill_q;
    reg exp_act_q;
    reg exp_stb_n_q;
    reg [3:0] exp_nib_q;

    wire [2:0] idx;
    wire [6:0] wr;
    reg [31:0] rd_data;
    wire idle;
    wire start;
    wire [7:0] pw;
    wire st_exp;

    // Decode of the latched opcode
    wire is_call;
    wire is_rtn;
    wire is_rtns;
    wire is_in;
    wire is_outp;
    wire is_anlp;
    wire is_orlp;
    wire is_inb;
    wire is_outb;
    wire is_anlb;
    wire is_orlb;
    wire is_movdi;
    wire is_movdo;
    wire is_andx;
    wire is_orx;
    wire is_exp;
    wire is_legal;
    wire port_op;
    wire p_sel2;
    wire [1:0] exp_sel;
    wire [3:0] sel_oh;
    wire [15:0] shd_flat;
    wire [3:0] shd_cur;
    reg [3:0] exp_wd;
    wire [15:0] stk_rd;
    wire push;

    assign idle = (state_q == ST_IDLE);
    assign start = wr[0] & idle;
    assign pw = PWDATA[7:0];
    assign st_exp = (pw[3:2] == 2'h3) &&
        ((pw[7:4] == 4'h0) || (pw[7:4] == 4'h3) ||
         (pw[7:4] == 4'h8) || (pw[7:4] == 4'h9));

    assign is_call = (op_q[4:0] == `CRP_OP_CALL); // [RULE1]
    assign is_rtn = (op_q == `CRP_OP_RTN); // [RULE3]
    assign is_rtns = (op_q == `CRP_OP_RTNS); // [RULE4]
    assign port_op = (op_q[1:0] != 2'h0) && (op_q[1:0] != 2'h3);
    assign is_in = port_op && ({op_q[7:2], 2'h0} == `CRP_OP_IN); // [RULE5]
    assign is_outp = port_op && ({op_q[7:2], 2'h0} == `CRP_OP_OUTP); // [RULE6]
    assign is_anlp = port_op && ({op_q[7:2], 2'h0} == `CRP_OP_ANLP); // [RULE7]
    assign is_orlp = port_op && ({op_q[7:2], 2'h0} == `CRP_OP_ORLP); // [RULE7]
    assign is_inb = (op_q == `CRP_OP_INB); // [RULE8]
    assign is_outb = (op_q == `CRP_OP_OUTB); // [RULE9]
    assign is_anlb = (op_q == `CRP_OP_ANLB); // [RULE10]
    assign is_orlb = (op_q == `CRP_OP_ORLB); // [RULE10]
    assign is_movdi = ({op_q[7:2], 2'h0} == `CRP_OP_MOVDI); // [RULE11]
    assign is_movdo = ({op_q[7:2], 2'h0} == `CRP_OP_MOVDO); // [RULE12]
    assign is_andx = ({op_q[7:2], 2'h0} == `CRP_OP_ANDX); // [RULE13]
    assign is_orx = ({op_q[7:2], 2'h0} == `CRP_OP_ORX); // [RULE13]
    assign is_exp = is_movdi | is_movdo | is_andx | is_orx;
    assign is_legal = is_call | is_rtn | is_rtns | is_in | is_outp |
        is_anlp | is_orlp | is_inb | is_outb | is_anlb | is_orlb | is_exp;
    assign p_sel2 = op_q[1];
    assign exp_sel = op_q[1:0]; // [RULE14]
    assign sel_oh = 4'h1 << exp_sel; // [RULE14]
    assign shd_cur = shd_flat[exp_sel*4 +: 4];

    // Value written to the expander port; AND/OR work on the kept latch
    always @* begin
        exp_wd = acc_q[3:0]; // [RULE12]
        if (is_andx) begin
            exp_wd = shd_cur & acc_q[3:0]; // [RULE13]
        end else if (is_orx) begin
            exp_wd = shd_cur | acc_q[3:0]; // [RULE13]
        end
    end

    // Shadow of each expander port latch; the expander cannot be read back cheaply
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_shd
            reg [3:0] shd_q;
            always @(posedge CLK or posedge SYS_RST) begin
                if (SYS_RST) begin
                    shd_q <= 4'h0;
                end else if ((state_q == ST_EX2) && is_exp && sel_oh[g]) begin
                    shd_q <= is_movdi ? P2_IN[3:0] : exp_wd; // [RULE13]
                end
            end
            assign shd_flat[g*4 +: 4] = shd_q;
        end
    endgenerate

    // Sequencer: every instruction takes two execute cycles
    always @* begin
        case (state_q)
            ST_IDLE: state_d = start ? ST_EX1 : ST_IDLE;
            ST_EX1: state_d = ST_EX2;
            ST_EX2: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_q <= ST_IDLE;
            op_q <= 8'h00;
            arg_q <= 8'h00;
            ill_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (start) begin
                op_q <= pw;
                arg_q <= PWDATA[15:8];
            end
            if (state_q == ST_EX1) begin
                ill_q <= ~is_legal;
            end
        end
    end

    // Return stack; push in the first cycle at the current pointer
    assign push = (state_q == ST_EX1) && is_call; // [RULE1]

    crp_stack #(
        .PW(3),
        .DW(16)
    ) u_stack (
        .clk(CLK),
        .we(push),
        .wptr(sp_q),
        .wdata({stw_q, pc_q}), // [RULE1]
        .rptr(sp_q),
        .rdata(stk_rd)
    );

    // Stack pointer, program counter and status word
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sp_q <= 3'h0;
            pc_q <= 12'h000;
            stw_q <= 4'h0;
            bank_q <= 1'b0;
        end else begin
            if (state_q == ST_EX1 && (is_rtn || is_rtns)) begin
                sp_q <= sp_q - 3'h1; // [RULE3] [RULE4] [RULE19]
            end else if (state_q == ST_EX2 && is_call) begin
                sp_q <= sp_q + 3'h1; // [RULE2] [RULE19]
            end
            if (state_q == ST_EX2 && is_call) begin
                pc_q <= {bank_q, op_q[7:5], arg_q}; // [RULE2]
            end else if (state_q == ST_EX2 && (is_rtn || is_rtns)) begin
                pc_q <= stk_rd[11:0]; // [RULE3] [RULE4]
            end else if (wr[2] && idle) begin
                pc_q <= PWDATA[11:0];
            end
            if (state_q == ST_EX2 && is_rtns) begin
                stw_q <= stk_rd[15:12]; // [RULE4]
            end else if (wr[3] && idle) begin
                stw_q <= PWDATA[`CRP_STAT_STW_LO +: 4];
            end
            if (wr[3] && idle) begin
                bank_q <= PWDATA[`CRP_STAT_BANK];
            end
        end
    end

    // Accumulator, port latches and bus latch
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            acc_q <= 8'h00;
            p1_q <= 8'hFF;
            p2_q <= 8'hFF;
            bus_q <= 8'h00;
            bus_oe_q <= 1'b0;
        end else if (state_q == ST_EX2) begin
            if (is_in) begin
                acc_q <= p_sel2 ? P2_IN : P1_IN; // [RULE5]
            end else if (is_inb) begin
                acc_q <= BUS_IN; // [RULE8]
            end else if (is_movdi) begin
                acc_q <= {4'h0, P2_IN[3:0]}; // [RULE11]
            end
            if (is_outp && !p_sel2) begin
                p1_q <= acc_q; // [RULE6]
            end else if (is_anlp && !p_sel2) begin
                p1_q <= p1_q & arg_q; // [RULE7]
            end else if (is_orlp && !p_sel2) begin
                p1_q <= p1_q | arg_q; // [RULE7]
            end
            if (is_outp && p_sel2) begin
                p2_q <= acc_q; // [RULE6]
            end else if (is_anlp && p_sel2) begin
                p2_q <= p2_q & arg_q; // [RULE7]
            end else if (is_orlp && p_sel2) begin
                p2_q <= p2_q | arg_q; // [RULE7]
            end
            if (is_outb) begin
                bus_q <= acc_q; // [RULE9]
                bus_oe_q <= 1'b1;
            end else if (is_anlb) begin
                bus_q <= bus_q & arg_q; // [RULE10]
                bus_oe_q <= 1'b1;
            end else if (is_orlb) begin
                bus_q <= bus_q | arg_q; // [RULE10]
                bus_oe_q <= 1'b1;
            end else if (is_inb) begin
                bus_oe_q <= 1'b0;
            end
        end else if (wr[1] && idle) begin
            acc_q <= PWDATA[7:0];
        end
    end

    // Expander transfer: command nibble in cycle 1, strobe low with data in cycle 2
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            exp_act_q <= 1'b0;
            exp_stb_n_q <= 1'b1;
            exp_nib_q <= 4'h0;
        end else if (start && st_exp) begin
            exp_act_q <= 1'b1;
            exp_nib_q <= {(pw[7:4] == 4'h0) ? `CRP_EXP_RD : `CRP_EXP_WR, pw[1:0]}; // [RULE14]
        end else if (state_q == ST_EX1 && is_exp) begin
            exp_stb_n_q <= 1'b0;
            exp_nib_q <= exp_wd; // [RULE12] [RULE13]
            exp_act_q <= ~is_movdi;
        end else if (state_q == ST_EX2) begin
            exp_stb_n_q <= 1'b1;
            exp_act_q <= 1'b0;
        end
    end

    // Timer and interrupt flags; a hardware set wins over a software clear
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tflg_q <= 1'b0; // [RULE15]
            tirq_q <= 1'b0; // [RULE15]
            tie_q <= 1'b0; // [RULE15]
            eie_q <= 1'b0; // [RULE15]
            gie_q <= 1'b1; // [RULE15]
        end else begin
            if (TMR_OVF) begin
                tflg_q <= 1'b1; // [RULE16]
            end else if (wr[4] && PWDATA[`CRP_INT_CLR_TFLG]) begin
                tflg_q <= 1'b0;
            end
            if (TMR_OVF && tie_q) begin
                tirq_q <= 1'b1; // [RULE16]
            end else if (wr[4] && PWDATA[`CRP_INT_CLR_REQ]) begin
                tirq_q <= 1'b0;
            end
            if (wr[4] && PWDATA[`CRP_INT_EN_TMR]) begin
                tie_q <= 1'b1; // [RULE17]
            end else if (wr[4] && PWDATA[`CRP_INT_DIS_TMR]) begin
                tie_q <= 1'b0; // [RULE17]
            end
            if (wr[4] && PWDATA[`CRP_INT_EN_EXT]) begin
                eie_q <= 1'b1; // [RULE18]
            end else if (wr[4] && PWDATA[`CRP_INT_DIS_EXT]) begin
                eie_q <= 1'b0; // [RULE18]
            end
            if (state_q == ST_EX2 && is_rtns) begin
                gie_q <= 1'b1; // [RULE4]
            end else if (wr[4] && PWDATA[`CRP_INT_CLR_GIE]) begin
                gie_q <= 1'b0;
            end
        end
    end

    // Read mux
    always @* begin
        rd_data = 32'h00000000;
        case (idx)
            3'h0: begin
                rd_data[15:0] = {arg_q, op_q};
                rd_data[`CRP_CMD_BUSY] = ~idle;
                rd_data[`CRP_CMD_ILL] = ill_q;
            end
            3'h1: rd_data[7:0] = acc_q;
            3'h2: rd_data[11:0] = pc_q;
            3'h3: begin
                rd_data[`CRP_STAT_STW_LO +: 4] = stw_q;
                rd_data[`CRP_STAT_BANK] = bank_q;
                rd_data[`CRP_STAT_SP_LO +: 3] = sp_q;
            end
            3'h4: rd_data[4:0] = {gie_q, eie_q, tie_q, tirq_q, tflg_q};
            3'h5: rd_data[24:0] = {bus_oe_q, bus_q, p2_q, p1_q};
            3'h6: rd_data[15:0] = shd_flat;
            default: rd_data = 32'h00000000;
        endcase
    end

    crp_apb u_apb (
        .clk(CLK),
        .rst(SYS_RST),
        .psel(PSEL),
        .penable(PENABLE),
        .pwrite(PWRITE),
        .paddr(PADDR),
        .prdata(PRDATA),
        .pready(PREADY),
        .pslverr(PSLVERR),
        .idx(idx),
        .wr_stb(wr),
        .rd_data(rd_data)
    );

    // Port 2 low nibble is lent to the expander only while a transfer runs
    assign P1_OUT = p1_q;
    assign P2_OUT = exp_act_q ? {p2_q[7:4], exp_nib_q} : p2_q;
    assign BUS_OUT = bus_q;
    assign BUS_OE = bus_oe_q;
    assign EXP_STB_N = exp_stb_n_q;
    assign TMR_IRQ = tirq_q;
    assign GIE = gie_q;
endmodule // crp_core

/* File: src/crp_map.vh */
// Register map, field positions and opcodes of the call/return and port I/O unit.
// Assumes byte addresses on a 32-bit APB with one aligned word per register.
`ifndef CRP_MAP_VH
`define CRP_MAP_VH

// Register byte offsets
`define CRP_OFF_CMD 12'h000
`define CRP_OFF_ACC 12'h004
`define CRP_OFF_PC 12'h008
`define CRP_OFF_STAT 12'h00C
`define CRP_OFF_INT 12'h010
`define CRP_OFF_PORT 12'h014
`define CRP_OFF_EXP 12'h018
`define CRP_REG_CNT 3'h7

// Command register fields
`define CRP_CMD_BUSY 16
`define CRP_CMD_ILL 17

// Status register fields
`define CRP_STAT_STW_LO 4
`define CRP_STAT_BANK 8
`define CRP_STAT_SP_LO 16

// Interrupt control write bits
`define CRP_INT_EN_TMR 0
`define CRP_INT_DIS_TMR 1
`define CRP_INT_EN_EXT 2
`define CRP_INT_DIS_EXT 3
`define CRP_INT_CLR_TFLG 4
`define CRP_INT_CLR_REQ 5
`define CRP_INT_CLR_GIE 6

// Interrupt status read bits
`define CRP_IST_TFLG 0
`define CRP_IST_TIRQ 1
`define CRP_IST_TIE 2
`define CRP_IST_EIE 3
`define CRP_IST_GIE 4

// Opcodes
`define CRP_OP_CALL 5'h14
`define CRP_OP_RTN 8'h83
`define CRP_OP_RTNS 8'h93
`define CRP_OP_IN 8'h08
`define CRP_OP_OUTP 8'h38
`define CRP_OP_ANLP 8'h98
`define CRP_OP_ORLP 8'h88
`define CRP_OP_INB 8'h08
`define CRP_OP_OUTB 8'h02
`define CRP_OP_ANLB 8'h98
`define CRP_OP_ORLB 8'h88
`define CRP_OP_MOVDI 8'h0C
`define CRP_OP_MOVDO 8'h3C
`define CRP_OP_ANDX 8'h9C
`define CRP_OP_ORX 8'h8C

// Expander command codes on the nibble
`define CRP_EXP_RD 2'h0
`define CRP_EXP_WR 2'h1

`endif

/* File: src/crp_stack.v */
// Eight-entry return stack holding program counter and upper status bits.
// Assumes the caller owns the stack pointer; read is combinational.
module crp_stack #(
    parameter PW = 3,
    parameter DW = 16
) (
    // Clock
    input wire clk,
    // Write side
    input wire we,
    input wire [PW-1:0] wptr,
    input wire [DW-1:0] wdata,
    // Read side
    input wire [PW-1:0] rptr,
    output wire [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<PW)-1];

    // No reset: entries are only read after being pushed
    always @(posedge clk) begin
        if (we) begin
            mem[wptr] <= wdata;
        end
    end

    assign rdata = mem[rptr];
endmodule // crp_stack

/* File: src/crp_apb.v */
// APB slave front end: decode, write strobes, registered read data.
// Assumes a zero-wait slave; the core supplies the read mux value.
`include "crp_map.vh"
module crp_apb (
    // Clock and reset
    input wire clk,
    input wire rst,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Core side
    output wire [2:0] idx,
    output wire [6:0] wr_stb,
    input wire [31:0] rd_data
);
    wire hit;

    assign idx = paddr[4:2];
    assign hit = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0) && (idx < `CRP_REG_CNT);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign wr_stb = (psel & penable & pwrite & hit) ? (7'h01 << idx) : 7'h00;

    // Read data captured in the setup cycle so it stands for the access phase
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable) begin
            prdata <= (hit & ~pwrite) ? rd_data : 32'h00000000;
        end
    end
endmodule // crp_apb

/* File: tb/crp_core_properties.sv */
// Concurrent checks on the pins of the call/return and port I/O unit.
// Assumes one clock and an asynchronous active-high reset.
module crp_core_checker (
    // Clock and reset
    input wire CLK,
    input wire SYS_RST,
    // APB
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    // Pins
    input wire [7:0] P1_OUT,
    input wire [7:0] P2_OUT,
    input wire BUS_OE,
    input wire EXP_STB_N,
    input wire TMR_OVF,
    input wire TMR_IRQ,
    input wire GIE
);
    wire cmd_wr = PSEL && PENABLE && PWRITE && PADDR == 12'h000;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // Reset itself is the cause here, so this one is never disabled
    property p_rst_state;
        disable iff (1'b0) SYS_RST |-> GIE && !TMR_IRQ && P1_OUT == 8'hFF && !BUS_OE;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
    property p_irq_cause;
        $rose(TMR_IRQ) |-> $past(TMR_OVF);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("request without overflow");
    property p_stb_len;
        $fell(EXP_STB_N) |=> EXP_STB_N;
    endproperty
    a_stb_len: assert property (p_stb_len) else $error("strobe longer than one cycle");
    property p_stb_sel;
        $fell(EXP_STB_N) |-> $past(cmd_wr, 2) && $past(P2_OUT[1:0]) == $past(PWDATA[1:0], 2);
    endproperty
    a_stb_sel: assert property (p_stb_sel) else $error("expander port select wrong");
    property p_stb_cmd;
        $fell(EXP_STB_N) |-> $past(P2_OUT[3:2]) == (($past(PWDATA[7:4], 2) == 4'h0) ? 2'h0 : 2'h1);
    endproperty
    a_stb_cmd: assert property (p_stb_cmd) else $error("expander command wrong");
    property p_p1_src;
        !$stable(P1_OUT) |-> $past(cmd_wr, 3);
    endproperty
    a_p1_src: assert property (p_p1_src) else $error("port 1 changed without op");
    property p_oe_rise;
        $rose(BUS_OE) |-> $past(cmd_wr, 3) && $past(PWDATA[7:0], 3) inside {8'h02, 8'h98, 8'h88};
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("bus drive without output op");
    property p_oe_fall;
        $fell(BUS_OE) |-> $past(cmd_wr, 3) && $past(PWDATA[7:0], 3) == 8'h08;
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("bus release without input op");
    property p_gie_rise;
        $rose(GIE) |-> $past(cmd_wr, 3) && $past(PWDATA[7:0], 3) == 8'h93;
    endproperty
    a_gie_rise: assert property (p_gie_rise) else $error("enable without restoring return");
endmodule // crp_core_checker

bind crp_core crp_core_checker u_crp_core_checker (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .P1_OUT(P1_OUT),
    .P2_OUT(P2_OUT), .BUS_OE(BUS_OE), .EXP_STB_N(EXP_STB_N), .TMR_OVF(TMR_OVF),
    .TMR_IRQ(TMR_IRQ), .GIE(GIE));

/* File: tb/crp_exp_model.sv */
// Nibble expander on port 2 low bits, four 4-bit ports.
// Assumes command nibble one cycle before the strobe, data while it is low.
module crp_exp_model (
    // Clock
    input wire clk,
    // Expander side
    input wire stb_n,
    input wire [3:0] nib_out,
    input wire [3:0] pin_lo,
    output logic [3:0] nib_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] mem [0:3];
    logic [3:0] cmd_q;
    initial cmd_q = 4'h0;
    always @(posedge clk) begin
        if (stb_n)
            cmd_q <= nib_out;
        else if (cmd_q[3:2] == 2'h1)
            mem[cmd_q[1:0]] <= nib_out;
    end
    // Outside a read strobe the pins show other logic, not the last nibble
    assign nib_in = (!stb_n && cmd_q[3:2] == 2'h0) ? mem[cmd_q[1:0]] : pin_lo;
endmodule // crp_exp_model

/* File: tb/crp_core_bench.sv */
// Self-checking bench for the call/return and port I/O unit.
// Drives APB, pins and timer; compares with a behavioural model.
module crp_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK, SYS_RST, PSEL, PENABLE, PWRITE, TMR_OVF, PREADY, PSLVERR;
    logic BUS_OE, EXP_STB_N, TMR_IRQ, GIE, err;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [7:0] P1_IN, P1_OUT, P2_OUT, BUS_IN, BUS_OUT;
    logic [3:0] p2_hi, pin_lo, nib_in;
    logic [10:0] a;
    integer n_errors, total_checks, i;
    int acc, pc, sp, stw, bnk, bus, oe, tflg, tirq, tie, eie, gie;
    int stk[8];
    int ex[4];
    int pt[2];

    crp_core u_crp_core (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .P1_IN(P1_IN), .P1_OUT(P1_OUT), .P2_IN({p2_hi, nib_in}),
        .P2_OUT(P2_OUT), .BUS_IN(BUS_IN), .BUS_OUT(BUS_OUT), .BUS_OE(BUS_OE),
        .EXP_STB_N(EXP_STB_N), .TMR_OVF(TMR_OVF), .TMR_IRQ(TMR_IRQ), .GIE(GIE));
    crp_exp_model u_crp_exp_model (.clk(CLK), .stb_n(EXP_STB_N), .nib_out(P2_OUT[3:0]),
        .pin_lo(pin_lo), .nib_in(nib_in));

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    task test_done;
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One transfer; an idle cycle after it keeps strobes from being reassigned
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int k;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge CLK);
            k++;
        end while (PREADY !== 1'b1 && k < 16);
        if (PREADY !== 1'b1) begin
            n_errors++;
            test_done();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask

    task check_all;
        apb(0, 12'h004, 0);
        chk(rd, acc);
        apb(0, 12'h008, 0);
        chk(rd, pc);
        apb(0, 12'h00C, 0);
        chk(rd, sp * 65536 + bnk * 256 + stw * 16);
        apb(0, 12'h010, 0);
        chk(rd, gie * 16 + eie * 8 + tie * 4 + tirq * 2 + tflg);
        chk({GIE, TMR_IRQ}, gie * 2 + tirq);
        apb(0, 12'h014, 0);
        chk(rd, oe * 2 ** 24 + bus * 65536 + pt[1] * 256 + pt[0]);
        chk({7'h0, BUS_OE, BUS_OUT, P2_OUT, P1_OUT},
            oe * 2 ** 24 + bus * 65536 + pt[1] * 256 + pt[0]);
    endtask

    task model(input int o, input int n);
        int s;
        s = o % 4;
        if (o % 32 == 20) begin
            stk[sp] = stw * 4096 + pc;
            sp = (sp + 1) % 8;
            pc = bnk * 2048 + (o / 32) * 256 + n;
        end
        case (o)
            'h83, 'h93: begin
                sp = (sp + 7) % 8;
                pc = stk[sp] % 4096;
                if (o == 'h93)
                    stw = stk[sp] / 4096;
                if (o == 'h93)
                    gie = 1;
            end
            'h09, 'h0A: acc = (s == 1) ? P1_IN : {p2_hi, pin_lo};
            'h39, 'h3A: pt[s - 1] = acc;
            'h99, 'h9A: pt[s - 1] &= n;
            'h89, 'h8A: pt[s - 1] |= n;
            'h08: acc = BUS_IN;
            'h02: bus = acc;
            'h98: bus &= n;
            'h88: bus |= n;
            'h0C, 'h0D, 'h0E, 'h0F: acc = ex[s];
            'h3C, 'h3D, 'h3E, 'h3F: ex[s] = acc % 16;
            'h9C, 'h9D, 'h9E, 'h9F: ex[s] &= acc;
            'h8C, 'h8D, 'h8E, 'h8F: ex[s] |= acc % 16;
            default: ;
        endcase
        if (o == 'h02 || o == 'h98 || o == 'h88)
            oe = 1;
        if (o == 'h08)
            oe = 0;
    endtask

    task op(input logic [7:0] o, input logic [7:0] n);
        int k;
        model(o, n);
        apb(1, 12'h000, {16'h0, n, o});
        k = 0;
        do begin
            apb(0, 12'h000, 0);
            k++;
        end while (rd[16] !== 1'b0 && k < 8);
        if (rd[16] !== 1'b0) begin
            n_errors++;
            test_done();
        end
        check_all();
    endtask

    task set_acc(input logic [7:0] v);
        apb(1, 12'h004, v);
        acc = v;
    endtask

    task pulse;
        TMR_OVF <= 1'b1;
        @(posedge CLK);
        TMR_OVF <= 1'b0;
        @(posedge CLK);
        tflg = 1;
        tirq = tirq | tie;
        check_all();
    endtask

    initial begin
        n_errors = 0;
        total_checks = 0;
        SYS_RST = 1'b0;
        {PSEL, PENABLE, PWRITE, TMR_OVF} = 4'h0;
        {PADDR, PWDATA} = 44'h0;
        {P1_IN, p2_hi, BUS_IN, pin_lo} = 24'h0;
        {acc, pc, bnk, stw, bus, oe, tflg, tirq, tie, eie} = '0;
        pt[0] = 255;
        pt[1] = 255;
        gie = 1;
        // A real edge on reset, so the design is reset before the first clock
        #2 SYS_RST = 1'b1;
        repeat (8) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        void'($urandom(85));
        apb(0, 12'h010, 0);
        chk(rd, 16);
        // Stack pointer resets to zero; the model reads it back and follows it
        apb(0, 12'h00C, 0);
        sp = rd[18:16];
        apb(0, 12'h01C, 0);
        chk(rd, 0);
        chk(err, 1);
        apb(1, 12'h008, 12'h5A5);
        pc = 'h5A5;
        for (i = 0; i < 9; i++) begin
            a = 11'($urandom);
            stw = i;
            bnk = i % 2;
            apb(1, 12'h00C, bnk * 256 + stw * 16);
            op({a[10:8], 5'h14}, a[7:0]);
        end
        for (i = 0; i < 4; i++) begin
            apb(1, 12'h010, 64);
            gie = 0;
            op(8'h83, 8'h00);
            op(8'h93, 8'h00);
        end
        for (i = 0; i < 6; i++) begin
            P1_IN <= 8'($urandom);
            p2_hi <= 4'($urandom);
            pin_lo <= 4'($urandom);
            BUS_IN <= 8'($urandom);
            set_acc(8'($urandom));
            op(8'h39 + i % 2, 8'h00);
            op(8'h99 + i % 2, 8'($urandom));
            op(8'h89 + i % 2, 8'($urandom));
            op(8'h09 + i % 2, 8'h00);
            op(8'h02, 8'h00);
            op(8'h98, 8'($urandom));
            op(8'h88, 8'($urandom));
            op(8'h08, 8'h00);
        end
        for (i = 0; i < 4; i++) begin
            set_acc(8'($urandom));
            op(8'h3C + i, 8'h00);
            set_acc(8'($urandom));
            op(8'h9C + i, 8'h00);
            op(8'h8C + i, 8'h00);
            op(8'h0C + i, 8'h00);
        end
        apb(0, 12'h018, 0);
        chk(rd, ex[3] * 4096 + ex[2] * 256 + ex[1] * 16 + ex[0]);
        pulse();
        apb(1, 12'h010, 1);
        tie = 1;
        pulse();
        apb(1, 12'h010, 6);
        tie = 0;
        eie = 1;
        apb(1, 12'h010, 48);
        tflg = 0;
        tirq = 0;
        check_all();
        apb(1, 12'h010, 8);
        eie = 0;
        pulse();
        test_done();
    end
endmodule // crp_core_bench
